// *** rtl/icp_top.sv ***
// protection and mode logic of an isolated can transceiver
// assumes analog comparators and adcs present digitised levels
// synchronous to clock; the bus drive outputs go to the analog driver
`timescale 1ns/1ps
module icp_top
#(
    parameter int unsigned DOMINANT_TIMEOUT_PERIOD =
        icp_pkg::DOMINANT_TIMEOUT_CYCLES,
    parameter int unsigned RESUME_DELAY = icp_pkg::UV_RESUME_CYCLES
)
(
    input wire logic clock,
    input wire logic rst_n,
    // host transmit input, low means dominant
    input wire logic txd,
    // pin floating indication, pull-up makes it read high
    input wire logic txd_float,
    // digitised differential input voltage in mV
    input wire logic signed [15:0] differential_input_voltage,
    // both bus lines open
    input wire logic bus_open,
    // logic side supply above its threshold
    input wire logic logic_side_supply_ok,
    // bus side supply in mV
    input wire logic [12:0] bus_side_supply,
    // junction above shutdown threshold
    input wire logic over_temp,
    // junction below threshold minus hysteresis
    input wire logic below_thermal_hysteresis,
    output logic rxd,
    output logic drive_dominant,
    output logic recessive_bias,
    output logic driver_enable,
    output logic dominant_timeout,
    output logic thermal_shutdown,
    output logic protected_mode
);
    import icp_pkg::*;

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    logic tx_level;
    logic tx_prev;
    logic tx_fall;
    logic tx_rise;
    logic bus_supply_ok;
    logic supplies_ok;

    // floating transmit pin reads recessive
    assign tx_level = txd | txd_float;

    // edges against the registered level, which idles high after reset
    assign tx_fall = tx_prev & ~tx_level;
    assign tx_rise = ~tx_prev & tx_level;

    // supply comparators; the logic side arrives already decided
    assign bus_supply_ok = bus_side_supply >= BUS_SUPPLY_UV_THRESHOLD_MV;
    assign supplies_ok = logic_side_supply_ok & bus_supply_ok;

    // previous transmit level for edge detection
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_prev <= 1'b1;
        end
        else
        begin
            tx_prev <= tx_level;
        end
    end

    // ------------------------------------------------------------
    // dominant timeout
    // ------------------------------------------------------------
    icp_timer_if dto_if ();

    // restart on falling edge, rising edge also resets the count
    assign dto_if.restart = tx_fall | tx_rise;
    assign dto_if.run = ~tx_level;

    icp_timer
    #(
        .LIMIT(DOMINANT_TIMEOUT_PERIOD)
    )
    u_dto_timer
    (
        .clock(clock),
        .rst_n(rst_n),
        .ctl(dto_if.timer)
    );

    // set on expiry while low; any high level clears it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dominant_timeout <= 1'b0;
        end
        else if (tx_level)
        begin
            dominant_timeout <= 1'b0;
        end
        else if (dto_if.expired)
        begin
            dominant_timeout <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // thermal shutdown
    // ------------------------------------------------------------
    // set wins; clearing needs the hysteresis point, not just threshold
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            thermal_shutdown <= 1'b0;
        end
        else if (over_temp)
        begin
            thermal_shutdown <= 1'b1;
        end
        else if (below_thermal_hysteresis)
        begin
            thermal_shutdown <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // undervoltage lockout and resume delay
    // ------------------------------------------------------------
    icp_timer_if uv_if ();
    icp_mode_t mode;

    assign uv_if.restart = ~supplies_ok;
    assign uv_if.run = (mode == ICP_RESUMING);

    icp_timer
    #(
        .LIMIT(RESUME_DELAY)
    )
    u_uv_timer
    (
        .clock(clock),
        .rst_n(rst_n),
        .ctl(uv_if.timer)
    );

    // a supply dip at any point drops straight back to protected
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode <= ICP_PROTECTED;
        end
        else if (!supplies_ok)
        begin
            mode <= ICP_PROTECTED;
        end
        else
        begin
            case (mode)
                ICP_PROTECTED:
                begin
                    mode <= ICP_RESUMING;
                end
                ICP_RESUMING:
                begin
                    if (uv_if.expired)
                    begin
                        mode <= ICP_FUNCTIONAL;
                    end
                end
                default:
                begin
                    mode <= ICP_FUNCTIONAL;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // driver
    // ------------------------------------------------------------
    logic mode_functional;
    logic next_driver_enable;
    logic next_drive_dominant;

    // only the functional mode may ever drive the bus
    assign mode_functional = (mode == ICP_FUNCTIONAL);

    // any single fault alone forces the bus recessive
    assign next_driver_enable = ~dominant_timeout & ~thermal_shutdown
        & mode_functional & supplies_ok;

    // low transmit drives the bus differentially
    assign next_drive_dominant = next_driver_enable
        & ~tx_level;

    // registered enable; one cycle of latency traded for clean outputs
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            driver_enable <= 1'b0;
        end
        else
        begin
            driver_enable <= next_driver_enable;
        end
    end

    // dominant drive towards the analog stage
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive_dominant <= 1'b0;
        end
        else
        begin
            drive_dominant <= next_drive_dominant;
        end
    end

    // bias is the complement, so any fault leaves the bus recessive
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            recessive_bias <= 1'b1;
        end
        else
        begin
            recessive_bias <= ~next_drive_dominant;
        end
    end

    // mode flag; high through lockout and the resume delay
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            protected_mode <= 1'b1;
        end
        else
        begin
            protected_mode <= ~mode_functional;
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    logic rx_decision;
    logic next_rx_decision;
    logic rx_forced;

    // either supply lost leaves receive at its default high
    assign rx_forced = ~bus_supply_ok | ~logic_side_supply_ok;

    // between thresholds the last decision holds
    always_comb
    begin
        next_rx_decision = rx_decision;
        if (bus_open)
        begin
            next_rx_decision = 1'b1;
        end
        else if (differential_input_voltage >= RX_DOMINANT_MV)
        begin
            next_rx_decision = 1'b0;
        end
        else if (differential_input_voltage <= RX_RECESSIVE_MV)
        begin
            next_rx_decision = 1'b1;
        end
    end

    // receiver keeps following the bus through timeout and shutdown
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_decision <= 1'b1;
        end
        else
        begin
            rx_decision <= next_rx_decision;
        end
    end

    // bus side lost: default high regardless of the comparator
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxd <= 1'b1;
        end
        else if (rx_forced)
        begin
            rxd <= 1'b1;
        end
        else
        begin
            rxd <= next_rx_decision;
        end
    end
endmodule

// *** rtl/icp_pkg.sv ***
// constants shared by the isolated can phy protection logic
// assumes a single 40 mhz clock and analog levels already digitised
// Operation
// - differential bus is dominant low, bias recessive high
// - host drives transmit input, receive output shows bus
// - receiver low at 900 mV, high at 500 mV
// - timeout timer starts on transmit falling edge
// - no rising edge before expiry disables driver
// - transmit returning high clears timeout, re-enables driver
// - in timeout bus recessive, receiver keeps following
// - over temperature turns driver off, receiver runs
// - thermal shutdown clears only below hysteresis point
// - either supply low enters protected default mode
// - bus supply below 4 V forces receive high
// - both supplies valid means normal functional operation
// - resume normal operation 300 us after undervoltage
// - floating inputs fall to safe default states
// - low transmit dominant, high or open recessive
package icp_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int unsigned CLOCK_HZ = 40000000;

    // ------------------------------------------------------------
    // receiver thresholds in millivolts
    // ------------------------------------------------------------
    localparam logic signed [15:0] RX_DOMINANT_MV = 16'sh384;
    localparam logic signed [15:0] RX_RECESSIVE_MV = 16'sh1f4;

    // ------------------------------------------------------------
    // supply thresholds in millivolts
    // ------------------------------------------------------------
    localparam logic [12:0] BUS_SUPPLY_UV_THRESHOLD_MV = 13'hfa0;

    // ------------------------------------------------------------
    // timing, figures in microseconds and derived cycle counts
    // ------------------------------------------------------------
    localparam int unsigned UV_RESUME_US = 300;
    localparam int unsigned UV_RESUME_CYCLES =
        (UV_RESUME_US * (CLOCK_HZ / 1000000) > 0) ?
        UV_RESUME_US * (CLOCK_HZ / 1000000) : 1;
    // period not fixed by the part family; plain default
    localparam int unsigned DOMINANT_TIMEOUT_PERIOD_US = 1000;
    localparam int unsigned DOMINANT_TIMEOUT_CYCLES =
        (DOMINANT_TIMEOUT_PERIOD_US * (CLOCK_HZ / 1000000) > 0) ?
        DOMINANT_TIMEOUT_PERIOD_US * (CLOCK_HZ / 1000000) : 1;
    localparam int TIMER_WIDTH = 24;

    // ------------------------------------------------------------
    // supply mode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ICP_PROTECTED,
        ICP_RESUMING,
        ICP_FUNCTIONAL
    } icp_mode_t;

endpackage

// *** rtl/icp_timer_if.sv ***
// carrier between the protection core and one of its timers
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface icp_timer_if;
    logic restart;
    logic run;
    logic expired;

    modport core
    (
        output restart,
        output run,
        input expired
    );

    modport timer
    (
        input restart,
        input run,
        output expired
    );
endinterface

// *** rtl/icp_timer.sv ***
// saturating cycle timer used for the timeout and resume delays
// assumes restart and run are synchronous to clock
`timescale 1ns/1ps
module icp_timer
#(
    parameter int unsigned LIMIT = 1
)
(
    input wire logic clock,
    input wire logic rst_n,
    icp_timer_if.timer ctl
);
    import icp_pkg::*;

    localparam logic [TIMER_WIDTH-1:0] LIMIT_W = TIMER_WIDTH'(LIMIT);

    logic [TIMER_WIDTH-1:0] count;

    // count up while running, stop at the limit; restart wins over run
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
        end
        else if (ctl.restart)
        begin
            count <= '0;
        end
        else if (ctl.run && count < LIMIT_W)
        begin
            count <= count + 1'b1;
        end
    end

    assign ctl.expired = (count >= LIMIT_W) && !ctl.restart;
endmodule

// *** bench/icp_props.sv ***
// assertions on the pins of the protection top
// assumes a bind onto icp_top handing on its parameters
`timescale 1ns/1ps
module icp_props
#(
    parameter int unsigned DOMINANT_TIMEOUT_PERIOD = 20,
    parameter int unsigned RESUME_DELAY = 10
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic txd,
    input wire logic txd_float,
    input wire logic signed [15:0] differential_input_voltage,
    input wire logic bus_open,
    input wire logic logic_side_supply_ok,
    input wire logic [12:0] bus_side_supply,
    input wire logic over_temp,
    input wire logic below_thermal_hysteresis,
    input wire logic rxd,
    input wire logic drive_dominant,
    input wire logic recessive_bias,
    input wire logic driver_enable,
    input wire logic dominant_timeout,
    input wire logic thermal_shutdown,
    input wire logic protected_mode
);
    import icp_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic [23:0] low_cnt;
    logic sup_ok;
    logic tx_low;
    // a floating pin reads high, so it never counts as dominant
    assign tx_low = !txd && !txd_float;
    assign sup_ok = logic_side_supply_ok &&
        bus_side_supply >= BUS_SUPPLY_UV_THRESHOLD_MV;
    // consecutive dominant samples of the transmit pin
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            low_cnt <= '0;
        else
            low_cnt <= tx_low ? low_cnt + 24'h1 : '0;
    end
    AST_RX_DOM: assert property (sup_ok && !bus_open &&
        differential_input_voltage >= RX_DOMINANT_MV |=> !rxd)
        else $error("rxd not low on dominant bus");
    AST_RX_REC: assert property (bus_open ||
        differential_input_voltage <= RX_RECESSIVE_MV |=> rxd)
        else $error("rxd not high on recessive or open bus");
    AST_RX_UV: assert property (!sup_ok |=> rxd)
        else $error("rxd not forced high on low supply");
    AST_TO_MIN: assert property ($rose(dominant_timeout) |->
        low_cnt >= DOMINANT_TIMEOUT_PERIOD)
        else $error("timeout flagged too early");
    AST_TO_MAX: assert property (tx_low &&
        low_cnt == DOMINANT_TIMEOUT_PERIOD + 6 |-> dominant_timeout)
        else $error("timeout not flagged");
    AST_GATE: assert property (dominant_timeout ||
        thermal_shutdown |=> !driver_enable && !drive_dominant)
        else $error("driver left on during a fault");
    AST_PROT: assert property (protected_mode &&
        $past(protected_mode) |-> !driver_enable)
        else $error("driver on in protected mode");
    AST_FOLLOW: assert property (driver_enable && tx_low
        ##1 driver_enable |-> drive_dominant)
        else $error("bus not dominant for low transmit");
    AST_REC_TX: assert property (!tx_low |=> !drive_dominant)
        else $error("bus dominant for high transmit");
    AST_TSD_SET: assert property (over_temp |=> thermal_shutdown)
        else $error("thermal flag not set");
    AST_TSD_HOLD: assert property (thermal_shutdown &&
        !below_thermal_hysteresis |=> thermal_shutdown)
        else $error("thermal flag cleared inside hysteresis");
endmodule

// *** bench/icp_host.sv ***
// host controller model driving the transmit pin
// assumes the bench calls send, or sets stuck to hold the pin low
`timescale 1ns/1ps
module icp_host
(
    input wire logic clock,
    output logic txd
);
    logic low = 1'b0;
    logic stuck = 1'b0;
    // push-pull drive idling high
    assign txd = !(low || stuck);
    // pulse low for n cycles, changed only on edges
    task automatic send(input int n);
        @(posedge clock);
        low <= 1'b1;
        repeat (n) @(posedge clock);
        low <= 1'b0;
    endtask
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the protection top
// assumes icp_top, icp_props and icp_host are compiled first
`timescale 1ns/1ps
module testbench;
    import icp_pkg::*;
    localparam int unsigned TO = 20;
    localparam int unsigned RD = 10;
    typedef struct packed {
        logic signed [15:0] v;
        logic op;
        logic rx;
    } icp_row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic txd;
    logic txd_float = 1'b0;
    logic signed [15:0] differential_input_voltage = 16'sh0;
    logic bus_open = 1'b0;
    logic logic_side_supply_ok = 1'b1;
    logic [12:0] bus_side_supply = 13'h1388;
    logic over_temp = 1'b0;
    logic below_thermal_hysteresis = 1'b1;
    logic rxd, drive_dominant, recessive_bias, driver_enable;
    logic dominant_timeout, thermal_shutdown, protected_mode;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    // between-band rows with the bus closed must hold the previous decision
    icp_row_t rows [8] = '{'{16'sh384, 1'b0, 1'b0},
        '{16'sh2bc, 1'b0, 1'b0}, '{16'sh1f4, 1'b0, 1'b1},
        '{16'sh2bc, 1'b0, 1'b1}, '{16'sh3e8, 1'b0, 1'b0},
        '{16'sh190, 1'b0, 1'b1}, '{16'sh3e8, 1'b0, 1'b0},
        '{16'sh2bc, 1'b1, 1'b1}};
    icp_top #(.DOMINANT_TIMEOUT_PERIOD(TO), .RESUME_DELAY(RD)) uut (.*);
    icp_host host (.*);
    initial forever #12.5 clock = ~clock;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wait_n(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    // count edges until functional, bounded
    task automatic resume();
        n = 0;
        while (protected_mode !== 1'b0 && n < 100)
        begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    // hang guard, far beyond the under two hundred cycles needed
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fails++;
            finish_test();
        end
    end
    initial
    begin
        wait_n(3);
        check({rxd, drive_dominant, recessive_bias, driver_enable,
            dominant_timeout, thermal_shutdown, protected_mode},
            7'h51);
        @(posedge clock) rst_n <= 1'b1;
        resume();
        check(n >= RD && n <= RD + 8, 1'b1);
        wait_n(1);
        check(driver_enable, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            differential_input_voltage <= rows[i].v;
            bus_open <= rows[i].op;
            wait_n(1);
            check(rxd, rows[i].rx);
        end
        @(posedge clock) bus_open <= 1'b0;
        fork
            host.send(4);
            begin
                wait_n(3);
                check({drive_dominant, recessive_bias}, 2'b10);
            end
        join
        @(posedge clock);
        txd_float <= 1'b1;
        host.stuck <= 1'b1;
        wait_n(3);
        check(drive_dominant, 1'b0);
        @(posedge clock);
        txd_float <= 1'b0;
        host.stuck <= 1'b0;
        // back-to-back short pulses, each rise restarts the timer
        repeat (2) host.send(TO - 4);
        wait_n(1);
        check(dominant_timeout, 1'b0);
        fork
            host.send(TO + 12);
            begin
                repeat (TO + 8) @(posedge clock);
                // dominant bus while timed out: receiver must follow
                differential_input_voltage <= 16'sh3e8;
                wait_n(2);
                check({dominant_timeout, driver_enable, drive_dominant,
                    recessive_bias, rxd}, 5'h12);
            end
        join
        wait_n(3);
        check({dominant_timeout, driver_enable}, 2'b01);
        @(posedge clock);
        over_temp <= 1'b1;
        below_thermal_hysteresis <= 1'b0;
        @(posedge clock) over_temp <= 1'b0;
        wait_n(4);
        check({thermal_shutdown, driver_enable}, 2'b10);
        @(posedge clock) below_thermal_hysteresis <= 1'b1;
        wait_n(3);
        check({thermal_shutdown, driver_enable}, 2'b01);
        // event and clear in the same cycle: the set must win
        @(posedge clock) over_temp <= 1'b1;
        @(posedge clock) over_temp <= 1'b0;
        wait_n(0);
        check(thermal_shutdown, 1'b1);
        @(posedge clock) bus_side_supply <= 13'hf9f;
        wait_n(3);
        check({protected_mode, driver_enable, rxd}, 3'b101);
        @(posedge clock) bus_side_supply <= 13'hfa0;
        resume();
        check(n >= RD && n <= RD + 8, 1'b1);
        @(posedge clock) logic_side_supply_ok <= 1'b0;
        wait_n(3);
        check({protected_mode, driver_enable}, 2'b10);
        @(posedge clock) logic_side_supply_ok <= 1'b1;
        resume();
        check(n >= RD && n <= RD + 8, 1'b1);
        // reset in mid-run; bus recessive so the first decision is high
        @(posedge clock);
        rst_n <= 1'b0;
        differential_input_voltage <= 16'sh0;
        wait_n(1);
        check({rxd, drive_dominant, recessive_bias, driver_enable,
            dominant_timeout, thermal_shutdown, protected_mode},
            7'h51);
        @(posedge clock) rst_n <= 1'b1;
        resume();
        check(n >= RD && n <= RD + 8, 1'b1);
        finish_test();
    end
endmodule
bind icp_top icp_props #(.DOMINANT_TIMEOUT_PERIOD(DOMINANT_TIMEOUT_PERIOD),
    .RESUME_DELAY(RESUME_DELAY)) props (.*);
